// ===== pkg/contact_override_pkg.sv
// constants, offsets and carrier types of the contact override block
package contact_override_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_FORCE_SEL  = 8'h04;
    localparam logic [7:0] OFS_FORCE_POS  = 8'h08;
    localparam logic [7:0] OFS_GRP_FORCE  = 8'h0C;
    localparam logic [7:0] OFS_FORCE_MODE = 8'h10;
    localparam logic [7:0] OFS_FORCE_TIME = 8'h14;
    localparam logic [7:0] OFS_DISARM     = 8'h18;
    localparam logic [7:0] OFS_DISARM_TIM = 8'h1C;
    localparam logic [7:0] OFS_STATUS     = 8'h20;
    localparam logic [7:0] OFS_DISARMED   = 8'h24;
    localparam logic [7:0] OFS_CONTACTS   = 8'h28;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h2C;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h30;

    // field positions
    localparam int CTRL_REBOOT_BIT   = 0;
    localparam int CTRL_DISCTL_BIT   = 1;
    localparam int CTRL_PHSET_BIT    = 2;
    localparam int GRP_POS_LSB       = 8;
    localparam int MODE_PERM_BIT     = 0;
    localparam int DIS_PERM_BIT      = 8;
    localparam int ST_FTMR_BIT       = 0;
    localparam int ST_DTMR_BIT       = 1;
    localparam int ST_HEALTH_BIT     = 2;
    localparam int ST_PHMIS_BIT      = 3;
    localparam int IRQ_FEXP_BIT      = 0;
    localparam int IRQ_DEXP_BIT      = 1;
    localparam int IRQ_PHMIS_BIT     = 2;
    localparam int IRQ_HLOST_BIT     = 3;
    localparam int IRQ_BITS          = 4;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_TIME = 16'h0000;

    // timer tick: one millisecond at the 20 MHz clock
    localparam int TICK_TIME_US = 1000;
    localparam int CLK_MHZ      = 20;
    localparam int TICK_CYCLES  = TICK_TIME_US * CLK_MHZ;

    // register bus request carrier
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } regReq_s;

endpackage

// ===== rtl/output_contact_force_disarm.sv
// force and disarm override logic for the relay output contacts
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ns

module override_timer #(
    parameter int TICKS = contact_override_pkg::TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        cancel,
    input  wire logic [15:0] load,
    output logic             running,
    output logic             expired
);
    import contact_override_pkg::*;

    logic [31:0] preQ;
    logic [15:0] cntQ;
    wire         tick   = (preQ == 32'(TICKS - 1));
    wire         lastMs = tick && (cntQ == 16'h0001);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            preQ <= RST_WORD;
        end else if (start || tick || !running) begin
            preQ <= RST_WORD;
        end else begin
            preQ <= preQ + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cntQ    <= RST_TIME;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                cntQ    <= load;
                running <= (load != RST_TIME);
            end else if (cancel) begin
                running <= 1'b0;
            end else if (running && tick) begin
                cntQ <= cntQ - 16'h0001;
                if (lastMs) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end
            end
        end
    end
endmodule // override_timer

module contact_slot (
    input  wire logic grpDisarm,
    input  wire logic forceOn,
    input  wire logic forceLevel,
    input  wire logic protDrive,
    input  wire logic latchHeld,
    input  wire logic holdActive,
    input  wire logic disarmedNow,
    input  wire logic contactNow,
    output logic      disarmedNext,
    output logic      contactNext
);
    wire mayEnter = !latchHeld && !holdActive;

    assign disarmedNext = grpDisarm && (disarmedNow || mayEnter);
    assign contactNext  = disarmedNow ? contactNow :
                          forceOn     ? forceLevel : protDrive;
endmodule // contact_slot

module output_contact_force_disarm #(
    parameter int GROUPS      = 4,
    parameter int OUTS        = 8,
    parameter int TICK_CYC    = contact_override_pkg::TICK_CYCLES
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire contact_override_pkg::regReq_s   busReq,
    output logic [31:0]                          rdData,
    input  wire logic [GROUPS*OUTS-1:0]          protCmd,
    input  wire logic [GROUPS*OUTS-1:0]          latched,
    input  wire logic [GROUPS*OUTS-1:0]          holdRunning,
    input  wire logic                            zoneIlkCmd,
    input  wire logic                            supervisionCmd,
    input  wire logic                            bootDone,
    input  wire logic                            protRunning,
    input  wire logic                            phaseMeasured,
    output logic [GROUPS*OUTS-1:0]               contacts,
    output logic                                 zoneIlkOut,
    output logic                                 supervisionOut,
    output logic                                 healthGreen,
    output logic                                 phaseMismatch,
    output logic                                 rebootReq,
    output logic                                 irq
);
    import contact_override_pkg::*;

    localparam int NOUT = GROUPS * OUTS;

    // software registers
    logic [2:0]          ctrl_q;
    logic [NOUT-1:0]     forceSel_q;
    logic [NOUT-1:0]     forcePos_q;
    logic [GROUPS-1:0]   grpForce_q;
    logic [GROUPS-1:0]   grpPos_q;
    logic                forcePerm_q;
    logic [15:0]         forceTime_q;
    logic [GROUPS-1:0]   disarmCmd_q;
    logic                disarmPerm_q;
    logic [15:0]         disarmTime_q;
    logic [IRQ_BITS-1:0] irqStat_q;
    logic [IRQ_BITS-1:0] irqMask_q;
    logic [31:0]         rd_q;

    // block state
    logic [NOUT-1:0]     disarmed_q;
    logic [NOUT-1:0]     contacts_q;
    logic                health_q;
    logic                phMis_q;
    logic                reboot_q;

    logic                forceRun;
    logic                forceExp;
    logic                disarmRun;
    logic                disarmExp;

    // address decode
    wire wrCtrl   = busReq.wr && (busReq.addr == OFS_CTRL);
    wire wrFSel   = busReq.wr && (busReq.addr == OFS_FORCE_SEL);
    wire wrFPos   = busReq.wr && (busReq.addr == OFS_FORCE_POS);
    wire wrGrp    = busReq.wr && (busReq.addr == OFS_GRP_FORCE);
    wire wrFMode  = busReq.wr && (busReq.addr == OFS_FORCE_MODE);
    wire wrFTime  = busReq.wr && (busReq.addr == OFS_FORCE_TIME);
    wire wrDis    = busReq.wr && (busReq.addr == OFS_DISARM);
    wire wrDTime  = busReq.wr && (busReq.addr == OFS_DISARM_TIM);
    wire wrIStat  = busReq.wr && (busReq.addr == OFS_IRQ_STAT);
    wire wrIMask  = busReq.wr && (busReq.addr == OFS_IRQ_MASK);

    // a force command write (re)starts the force timer
    wire forceStart = wrFSel || wrGrp;
    wire disStart   = wrDis;

    // force live while permanent or while its timer runs
    // timed force gate
    wire forceLive  = forcePerm_q || forceRun;
    wire disarmLive = disarmPerm_q || disarmRun;
    wire disCtl     = ctrl_q[CTRL_DISCTL_BIT];

    override_timer #(
        .TICKS (TICK_CYC)
    ) u_force_tmr (
        .clk     (clk),
        .rstn    (rstn),
        .start   (forceStart),
        .cancel  (wrFMode),
        .load    (forceTime_q),
        .running (forceRun),
        .expired (forceExp)
    );

    override_timer #(
        .TICKS (TICK_CYC)
    ) u_disarm_tmr (
        .clk     (clk),
        .rstn    (rstn),
        .start   (disStart),
        .cancel  (wrFMode),
        .load    (disarmTime_q),
        .running (disarmRun),
        .expired (disarmExp)
    );

    // per output next state
    wire  [NOUT-1:0] disarmedD;
    wire  [NOUT-1:0] contactsD;

    for (genvar i = 0; i < NOUT; i++) begin : g_out
        localparam int G = i / OUTS;
        wire grpDis  = disarmCmd_q[G] && disarmLive && disCtl;
        wire forced  = forceLive && (grpForce_q[G] || forceSel_q[i]);
        wire pos     = grpForce_q[G] ? grpPos_q[G] : forcePos_q[i];

        contact_slot u_slot (
            .grpDisarm    (grpDis),
            .forceOn      (forced),
            .forceLevel   (pos),
            .protDrive    (protCmd[i]),
            .latchHeld    (latched[i]),
            .holdActive   (holdRunning[i]),
            .disarmedNow  (disarmed_q[i]),
            .contactNow   (contacts_q[i]),
            .disarmedNext (disarmedD[i]),
            .contactNext  (contactsD[i])
        );
    end

    // control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q     <= 3'h0;
            forceSel_q <= '0;
            forcePos_q <= '0;
            grpForce_q <= '0;
            grpPos_q   <= '0;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= busReq.wdata[2:0];
            end
            if (wrFSel) begin
                forceSel_q <= busReq.wdata[NOUT-1:0];
            end else if (forceExp && !forcePerm_q) begin
                forceSel_q <= '0;
            end
            if (wrFPos) begin
                forcePos_q <= busReq.wdata[NOUT-1:0];
            end
            if (wrGrp) begin
                grpForce_q <= busReq.wdata[GROUPS-1:0];
                grpPos_q   <= busReq.wdata[GRP_POS_LSB +: GROUPS];
            end else if (forceExp && !forcePerm_q) begin
                grpForce_q <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            forcePerm_q  <= 1'b0;
            forceTime_q  <= RST_TIME;
            disarmCmd_q  <= '0;
            disarmPerm_q <= 1'b0;
            disarmTime_q <= RST_TIME;
        end else begin
            if (wrFMode) begin
                forcePerm_q <= busReq.wdata[MODE_PERM_BIT];
            end
            if (wrFTime) begin
                forceTime_q <= busReq.wdata[15:0];
            end
            if (wrDis) begin
                disarmCmd_q  <= busReq.wdata[GROUPS-1:0];
                disarmPerm_q <= busReq.wdata[DIS_PERM_BIT];
            end else if (disarmExp && !disarmPerm_q) begin
                disarmCmd_q <= '0;
            end
            if (wrDTime) begin
                disarmTime_q <= busReq.wdata[15:0];
            end
        end
    end

    // contact state and status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disarmed_q     <= '0;
            contacts_q     <= '0;
            zoneIlkOut     <= 1'b0;
            supervisionOut <= 1'b0;
            health_q       <= 1'b0;
            phMis_q        <= 1'b0;
            reboot_q       <= 1'b0;
        end else begin
            disarmed_q     <= disarmedD;
            contacts_q     <= contactsD;
            zoneIlkOut     <= zoneIlkCmd;
            supervisionOut <= supervisionCmd;
            health_q       <= bootDone && protRunning;
            phMis_q        <= phaseMeasured != ctrl_q[CTRL_PHSET_BIT];
            reboot_q       <= wrCtrl && busReq.wdata[CTRL_REBOOT_BIT];
        end
    end

    // interrupt events
    wire  [IRQ_BITS-1:0] irqEvt;
    assign irqEvt[IRQ_FEXP_BIT]  = forceExp;
    assign irqEvt[IRQ_DEXP_BIT]  = disarmExp;
    assign irqEvt[IRQ_PHMIS_BIT] = phMis_q == 1'b0 &&
                                   (phaseMeasured != ctrl_q[CTRL_PHSET_BIT]);
    assign irqEvt[IRQ_HLOST_BIT] = health_q && !(bootDone && protRunning);

    wire [IRQ_BITS-1:0] w1c = wrIStat ? busReq.wdata[IRQ_BITS-1:0] : '0;

    // sticky status, set wins over clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irqStat_q <= '0;
            irqMask_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~w1c) | irqEvt;
            if (wrIMask) begin
                irqMask_q <= busReq.wdata[IRQ_BITS-1:0];
            end
        end
    end

    // read mux
    logic [31:0] rdMux;
    wire  [31:0] statusWord = {28'h0000000,
                               phMis_q, health_q, disarmRun, forceRun};

    always_comb begin
        rdMux = RST_WORD;
        unique case (busReq.addr)
            OFS_CTRL:       rdMux = {29'h0, ctrl_q[2:1], 1'b0};
            OFS_FORCE_SEL:  rdMux = 32'(forceSel_q);
            OFS_FORCE_POS:  rdMux = 32'(forcePos_q);
            OFS_GRP_FORCE:  rdMux = 32'(grpForce_q) |
                                    (32'(grpPos_q) << GRP_POS_LSB);
            OFS_FORCE_MODE: rdMux = {31'h0, forcePerm_q};
            OFS_FORCE_TIME: rdMux = {16'h0, forceTime_q};
            OFS_DISARM:     rdMux = 32'(disarmCmd_q) |
                                    (32'(disarmPerm_q) << DIS_PERM_BIT);
            OFS_DISARM_TIM: rdMux = {16'h0, disarmTime_q};
            OFS_STATUS:     rdMux = statusWord;
            OFS_DISARMED:   rdMux = 32'(disarmed_q);
            OFS_CONTACTS:   rdMux = 32'(contacts_q);
            OFS_IRQ_STAT:   rdMux = 32'(irqStat_q);
            OFS_IRQ_MASK:   rdMux = 32'(irqMask_q);
            default:        rdMux = RST_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_q <= RST_WORD;
        end else begin
            rd_q <= busReq.rd ? rdMux : RST_WORD;
        end
    end

    assign rdData        = rd_q;
    assign contacts      = contacts_q;
    assign healthGreen   = health_q;
    assign phaseMismatch = phMis_q;
    assign rebootReq     = reboot_q;
    assign irq           = |(irqStat_q & irqMask_q);

endmodule // output_contact_force_disarm

// ===== dv/contact_override_sva.sv
// concurrent checks on the contact override block ports
`timescale 1ns/1ns
module contact_override_sva #(
    parameter int GROUPS = 4,
    parameter int OUTS   = 8
) (
    input wire logic                          clk,
    input wire logic                          rstn,
    input wire contact_override_pkg::regReq_s busReq,
    input wire logic [31:0]                   rdData,
    input wire logic [GROUPS*OUTS-1:0]        protCmd,
    input wire logic [GROUPS*OUTS-1:0]        contacts,
    input wire logic                          zoneIlkCmd,
    input wire logic                          supervisionCmd,
    input wire logic                          bootDone,
    input wire logic                          protRunning,
    input wire logic                          phaseMeasured,
    input wire logic                          zoneIlkOut,
    input wire logic                          supervisionOut,
    input wire logic                          healthGreen,
    input wire logic                          phaseMismatch,
    input wire logic                          rebootReq
);
    import contact_override_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic touched_q;
    wire cfgWr = busReq.wr
                 && busReq.addr inside {[OFS_FORCE_SEL:OFS_DISARM_TIM]};
    wire rebootWr = busReq.wr && busReq.addr == OFS_CTRL
                    && busReq.wdata[CTRL_REBOOT_BIT];
    // marks the first force or disarm setting
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            touched_q <= 1'b0;
        end else if (cfgWr) begin
            touched_q <= 1'b1;
        end
    end
    exempt_follow_a: assert property ($past(rstn) |->
        {zoneIlkOut, supervisionOut} == $past({zoneIlkCmd, supervisionCmd}))
        else $error("exempt outputs not following their drive");
    health_led_a: assert property ($past(rstn) |->
        healthGreen == $past(bootDone && protRunning))
        else $error("health indicator wrong");
    phase_track_a: assert property ($past(rstn, 2)
        && !$past(busReq.wr, 2)
        && $past(phaseMeasured) != $past(phaseMeasured, 2)
        |-> phaseMismatch != $past(phaseMismatch))
        else $error("mismatch did not follow measured rotation");
    reboot_pulse_a: assert property (rebootWr |=> rebootReq)
        else $error("reboot request missing");
    reboot_cause_a: assert property (rebootReq |-> $past(rebootWr))
        else $error("reboot request without cause");
    reboot_single_a: assert property (rebootReq && !rebootWr
        |=> !rebootReq)
        else $error("reboot request longer than one cycle");
    contact_read_a: assert property (
        $past(busReq.rd && busReq.addr == OFS_CONTACTS)
        |-> rdData[GROUPS*OUTS-1:0] == $past(contacts))
        else $error("contact readback wrong");
    normal_follow_a: assert property ($past(rstn) && !touched_q
        |-> contacts == $past(protCmd))
        else $error("contacts not following protection drive");
endmodule // contact_override_sva

bind output_contact_force_disarm contact_override_sva #(
    .GROUPS(GROUPS),
    .OUTS(OUTS)
) chk (
    .clk(clk), .rstn(rstn), .busReq(busReq), .rdData(rdData),
    .protCmd(protCmd), .contacts(contacts), .zoneIlkCmd(zoneIlkCmd),
    .supervisionCmd(supervisionCmd), .bootDone(bootDone),
    .protRunning(protRunning), .phaseMeasured(phaseMeasured),
    .zoneIlkOut(zoneIlkOut), .supervisionOut(supervisionOut),
    .healthGreen(healthGreen), .phaseMismatch(phaseMismatch),
    .rebootReq(rebootReq)
);

// ===== dv/relay_bank_model.sv
// behavioural relay bank that the contact outputs drive
`timescale 1ns/1ns
module relay_bank_model #(
    parameter int N      = 32,
    parameter int PICKUP = 2
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [N-1:0] drive,
    input  wire logic [N-1:0] watch,
    output logic [N-1:0]      closed,
    output int                moves
);
    logic [N-1:0] pipe [PICKUP];
    // armature follows the coil after the pickup time, moves of watched relays are counted
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pipe <= '{default: '0};
            moves <= 0;
        end else begin
            pipe[0] <= drive;
            for (int i = 1; i < PICKUP; i++) pipe[i] <= pipe[i-1];
            moves <= moves + $countones((drive ^ pipe[0]) & watch);
        end
    end
    assign closed = pipe[PICKUP-1];
endmodule // relay_bank_model

// ===== dv/testbench.sv
// randomised self-checking bench for the contact override block
`timescale 1ns/1ns
module testbench;
    import contact_override_pkg::*;
    localparam int N = 32;
    logic         clk, rstn, bootDone, protRunning, phaseMeasured;
    logic         zoneIlkCmd, supervisionCmd, zoneIlkOut, supervisionOut;
    logic         healthGreen, phaseMismatch, rebootReq, irq;
    regReq_s      busReq;
    logic [31:0]  rdData;
    logic [N-1:0] protCmd, latched, holdRunning, contacts, closed;
    logic [N-1:0] watch, last, frz;
    int           miscompares, total_checks, moves, m0;
    logic [7:0]   rstRegs [5] = '{OFS_FORCE_SEL, OFS_GRP_FORCE, OFS_DISARM,
                                  OFS_IRQ_MASK, 8'h3C};

    output_contact_force_disarm #(.GROUPS(4), .OUTS(8), .TICK_CYC(4)) uut (
        .clk(clk), .rstn(rstn), .busReq(busReq), .rdData(rdData),
        .protCmd(protCmd), .latched(latched), .holdRunning(holdRunning),
        .zoneIlkCmd(zoneIlkCmd), .supervisionCmd(supervisionCmd),
        .bootDone(bootDone), .protRunning(protRunning),
        .phaseMeasured(phaseMeasured), .contacts(contacts),
        .zoneIlkOut(zoneIlkOut), .supervisionOut(supervisionOut),
        .healthGreen(healthGreen), .phaseMismatch(phaseMismatch),
        .rebootReq(rebootReq), .irq(irq));
    relay_bank_model #(.N(N), .PICKUP(2)) relays (.clk(clk), .rstn(rstn),
        .drive(contacts), .watch(watch), .closed(closed), .moves(moves));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [N-1:0] mix(input logic [N-1:0] p, m, v);
        return (p & ~m) | (v & m);
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq.wr <= 1'b1;
        busReq.addr <= a;
        busReq.wdata <= d;
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        busReq.rd <= 1'b1;
        busReq.addr <= a;
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 cmp(rdData, exp);
    endtask
    // random protection drive, contacts checked against mask and value
    task automatic follow(input logic [N-1:0] m, v, input int n);
        logic [N-1:0] p;
        repeat (n) begin
            p = $urandom;
            @(posedge clk);
            protCmd <= p;
            zoneIlkCmd <= p[0];
            supervisionCmd <= p[1];
            @(posedge clk);
            #1 cmp(contacts, mix(p, m, v));
            cmp({zoneIlkOut, supervisionOut}, {p[0], p[1]});
            last = p;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_of_test;
    end

    initial begin
        void'($urandom(92));
        rstn = 1'b0;
        busReq = '0;
        protCmd = '0;
        latched = '0;
        holdRunning = '0;
        {zoneIlkCmd, supervisionCmd, bootDone, protRunning} = 4'h0;
        phaseMeasured = 1'b0;
        watch = '0;
        last = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        foreach (rstRegs[i]) rd_chk(rstRegs[i], RST_WORD);
        follow('0, '0, 16);
        rd_chk(OFS_CONTACTS, last);
        cmp(closed, last);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {protRunning, bootDone} <= i[1:0];
            @(posedge clk);
            #1 cmp(healthGreen, i == 3);
        end
        wr(OFS_CTRL, 32'h1);
        #1 cmp(rebootReq, 1'b1);
        @(posedge clk);
        #1 cmp(rebootReq, 1'b0);
        wr(OFS_IRQ_MASK, 32'h4);
        wr(OFS_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        #1 cmp({irq, phaseMismatch}, 2'h3);
        wr(OFS_IRQ_STAT, 32'h4);
        #1 cmp(irq, 1'b0);
        @(posedge clk);
        phaseMeasured <= 1'b1;
        repeat (2) @(posedge clk);
        #1 cmp(phaseMismatch, 1'b0);
        wr(OFS_FORCE_MODE, 32'h1);
        wr(OFS_FORCE_POS, 32'hA5A5_A5A5);
        wr(OFS_FORCE_SEL, 32'h0000_FF0F);
        wr(OFS_GRP_FORCE, 32'h0000_0202);
        follow(32'hFF0F, 32'hFF05, 4);
        repeat (40) @(posedge clk);
        follow(32'hFF0F, 32'hFF05, 2);
        wr(OFS_GRP_FORCE, 32'h0);
        wr(OFS_FORCE_SEL, 32'h0);
        follow('0, '0, 3);
        wr(OFS_FORCE_MODE, 32'h0);
        wr(OFS_FORCE_TIME, 32'h4);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_FORCE_SEL, 32'hF000_0000);
        follow(32'hF000_0000, 32'hA000_0000, 2);
        rd_chk(OFS_STATUS, 32'h5);
        repeat (30) @(posedge clk);
        follow('0, '0, 2);
        cmp(irq, 1'b1);
        wr(OFS_IRQ_STAT, 32'hF);
        wr(OFS_DISARM, 32'h0000_0104);
        follow('0, '0, 2);
        rd_chk(OFS_DISARMED, 32'h0);
        wr(OFS_DISARM, 32'h0);
        latched <= 32'h1;
        holdRunning <= 32'h2;
        wr(OFS_CTRL, 32'h6);
        wr(OFS_DISARM, 32'h0000_0101);
        frz = last;
        watch <= 32'hFC;
        m0 = moves;
        follow(32'hFC, frz, 4);
        cmp(moves - m0, 0);
        @(posedge clk);
        latched <= '0;
        holdRunning <= '0;
        repeat (3) @(posedge clk);
        frz[1:0] = last[1:0];
        follow(32'hFF, frz, 3);
        rd_chk(OFS_DISARMED, 32'hFF);
        wr(OFS_FORCE_MODE, 32'h1);
        wr(OFS_GRP_FORCE, 32'h0000_0101);
        follow(32'hFF, frz, 2);
        wr(OFS_DISARM, 32'h0);
        follow(32'hFF, 32'hFF, 2);
        wr(OFS_GRP_FORCE, 32'h0);
        wr(OFS_DISARM_TIM, 32'h3);
        wr(OFS_IRQ_MASK, 32'h2);
        wr(OFS_IRQ_STAT, 32'hF);
        wr(OFS_DISARM, 32'h0000_0008);
        frz = last;
        follow(32'hFF00_0000, frz, 2);
        repeat (30) @(posedge clk);
        follow('0, '0, 2);
        cmp(irq, 1'b1);
        wr(OFS_IRQ_MASK, 32'h8);
        bootDone <= 1'b0;
        repeat (2) @(posedge clk);
        #1 cmp({irq, healthGreen}, 2'h2);
        end_of_test;
    end
endmodule // testbench
